//--- src/fcp_regs.svh
// offsets, field positions, reset values and command codes of the flash sequencer
// assumes a 16-bit cpu address space with the control block in high-page space
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH

// ----------------------------------------------------------------
// control register addresses
// ----------------------------------------------------------------
`define FCP_ADDR_CLKDIV 16'h1820
`define FCP_ADDR_PROT 16'h1824
`define FCP_ADDR_STATUS 16'h1825
`define FCP_ADDR_CMD 16'h1826
`define FCP_ADDR_PROT_NV 16'hFFBD
`define FCP_ADDR_OPT_NV 16'hFFBF

// ----------------------------------------------------------------
// status, protection and option fields
// ----------------------------------------------------------------
`define FCP_ST_CBEF 7
`define FCP_ST_CCF 6
`define FCP_ST_PVIOL 5
`define FCP_ST_ACCERR 4
`define FCP_PROT_DIS 0
`define FCP_OPT_NORED 6

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FCP_CMD_BLANK 8'h05
`define FCP_CMD_BYTE 8'h20
`define FCP_CMD_BURST 8'h25
`define FCP_CMD_PAGE 8'h40
`define FCP_CMD_MASS 8'h41

// ----------------------------------------------------------------
// vectors, rows, reset values, timing in flash clock cycles
// ----------------------------------------------------------------
`define FCP_VEC_LO 16'hFFC0
`define FCP_VEC_HI 16'hFFFD
`define FCP_ROW_MSB 5
`define FCP_LOW_FILL 9'h1FF
`define FCP_TOP_ADDR 16'hFFFF
`define FCP_RST_BYTE 8'h00
`define FCP_CYC_BYTE 9
`define FCP_CYC_BURST 4
`define FCP_CYC_PAGE 4000
`define FCP_CYC_MASS 20000
`define FCP_CYC_BLANK 9

`endif

//--- src/fcp_pkg.sv
// types shared by the flash sequencer and its bench
// assumes fcp_regs.svh supplies the numbers
package fcp_pkg;

  typedef enum logic [1:0] {
    FCP_PH_IDLE = 2'b00,
    FCP_PH_ADDR = 2'b01,
    FCP_PH_CMD = 2'b10
  } fcp_phase_t;

  typedef enum logic [0:0] {
    FCP_EX_IDLE = 1'b0,
    FCP_EX_RUN = 1'b1
  } fcp_exst_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] code;
  } fcp_cmd_t;

endpackage : fcp_pkg

//--- src/fcp_timer.sv
// flash clock prescaler and pulse counter for one program or erase operation
// assumes start arrives only while idle or on the done cycle, and divider is stable while busy
module fcp_timer #(
  parameter int CW = 15
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [6:0] div,
  input wire logic start,
  input wire logic [CW-1:0] count,
  input wire logic abort,
  output logic busy,
  output logic done
);

  if (CW < 2) begin : gChk
    $error("fcp_timer: counter width too small");
  end

  logic [6:0] pre_r, pre_nxt;
  logic [CW-1:0] rem_r, rem_nxt;
  logic tick;

  assign tick = (pre_r == div);
  assign busy = (rem_r != '0);
  assign done = busy && tick && (rem_r == CW'(1));

  always_comb begin
    pre_nxt = tick ? 7'h00 : pre_r + 7'h01;
    rem_nxt = rem_r;
    if (abort) begin
      rem_nxt = '0;
    end else if (start) begin
      rem_nxt = count;
      pre_nxt = 7'h00;
    end else if (busy && tick) begin
      rem_nxt = rem_r - CW'(1);
    end
    if (!busy && !start) begin
      pre_nxt = 7'h00;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pre_r <= 7'h00;
      rem_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      rem_r <= rem_nxt;
    end
  end

endmodule : fcp_timer

//--- src/fcp_ctrl.sv
// flash command sequencer: protocol checks, burst pump hold, protection, vector redirect
// assumes a cpu or background debug bus with one-cycle read and write strobes
// Notes on behaviour
// - pump stays on after a burst byte only if the next burst is queued
// - rows are 64 bytes, byte chosen by address bits 5..0
// - next address at a new row drops the pump and uses standard time
// - first burst byte takes standard time, later chained bytes burst time
// - nothing queued at completion switches the pump off
// - no command launches while access error is set; write 1 clears it
// - array write before the divider is written is an access error
// - array write while command buffer is not empty is an access error
// - second array write before launch is an access error
// - second command code write before launch is an access error
// - after array write, writing any control register but command is an error
// - command codes other than 05 20 25 40 41 are access errors
// - after command code, any control access but the launch write is an error
// - stop mode during program or erase aborts it and flags an error
// - secured debug may only blank check or mass erase
// - writing 0 to buffer empty cancels the partial command with an error
// - program and erase of the protected region are refused
// - protection loads from the nonvolatile byte; only debug may write it
// - last unprotected address is start bits with all lower bits one
// - protection is on only when the disable bit is 0
// - redirect only with no-redirect bit 0 and partial protection
// - vectors ffc0..fffd redirect; reset vector fffe never does
// - writing 1 to buffer empty launches the staged command and clears it
// - command complete rises when the launched command has finished
`include "fcp_regs.svh"

module fcp_ctrl #(
  parameter logic [15:0] FLASH_START = 16'h0870,
  parameter int CYC_BYTE = `FCP_CYC_BYTE,
  parameter int CYC_BURST = `FCP_CYC_BURST,
  parameter int CYC_PAGE = `FCP_CYC_PAGE,
  parameter int CYC_MASS = `FCP_CYC_MASS,
  parameter int CYC_BLANK = `FCP_CYC_BLANK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic busBdm,
  input wire logic secured,
  input wire logic stopMode,
  input wire logic [7:0] nvProtByte,
  input wire logic [7:0] nvOptByte,
  input wire logic vecFetch,
  output logic [7:0] rdData,
  output logic [15:0] fetchAddr,
  output logic pumpOn,
  output logic arrBusy,
  output fcp_pkg::fcp_cmd_t arrCmd
);

  if (CYC_MASS >= 32768 || CYC_BYTE < 1 || CYC_BURST < 1 || CYC_BLANK < 1 || CYC_PAGE < 1)
  begin : gChk
    $error("fcp_ctrl: operation counts outside 1..32767");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic rstSyncN;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync_r[1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] regSel(input logic [15:0] a);
    unique case (a)
      `FCP_ADDR_CLKDIV: regSel = 3'd1;
      `FCP_ADDR_PROT: regSel = 3'd2;
      `FCP_ADDR_STATUS: regSel = 3'd3;
      `FCP_ADDR_CMD: regSel = 3'd4;
      default: regSel = 3'd0;
    endcase
  endfunction : regSel

  function automatic logic isChange(input logic [7:0] c);
    isChange = (c == `FCP_CMD_BYTE) || (c == `FCP_CMD_BURST) || (c == `FCP_CMD_PAGE);
  endfunction : isChange

  logic [2:0] sel;
  logic arrWr, ctlWr, ctlRd, cmdWr, statWr, validCode;
  assign sel = regSel(busAddr);
  assign arrWr = busWr && (sel == 3'd0) && (busAddr >= FLASH_START);
  assign ctlWr = busWr && (sel != 3'd0);
  assign ctlRd = busRd && (sel != 3'd0);
  assign cmdWr = busWr && (sel == 3'd4);
  assign statWr = busWr && (sel == 3'd3);
  assign validCode = (busWrData == `FCP_CMD_BLANK) || isChange(busWrData) ||
                     (busWrData == `FCP_CMD_MASS);

  // ----------------------------------------------------------------
  // registers, staging and error checks
  // ----------------------------------------------------------------
  fcp_pkg::fcp_phase_t phase_r, phase_nxt;
  fcp_pkg::fcp_cmd_t stage_r, stage_nxt, queue_r, queue_nxt;
  logic qValid_r, qValid_nxt, cbef_r, cbef_nxt, accErr_r, accErr_nxt;
  logic pViol_r, pViol_nxt, divDone_r, divDone_nxt, loaded_r, loaded_nxt;
  logic [6:0] div_r, div_nxt;
  logic [7:0] workProt_r, workProt_nxt, opt_r, opt_nxt, rdData_r, rdData_nxt;
  logic [15:0] fetch_r, fetch_nxt;
  logic errSet, launch, blocked, exTake, stopErr, protEn, redirOn, hitProt, ccf;
  logic [15:0] lastUnprot, protSize;

  assign blocked = accErr_r || pViol_r;
  assign protEn = !workProt_r[`FCP_PROT_DIS];
  assign lastUnprot = {workProt_r[7:1], `FCP_LOW_FILL};
  assign protSize = `FCP_TOP_ADDR - lastUnprot;
  assign redirOn = !opt_r[`FCP_OPT_NORED] && protEn && (lastUnprot >= FLASH_START);
  // mass erase touches the whole array, so any protection refuses it
  assign hitProt = protEn && isChange(stage_r.code) ? (stage_r.addr > lastUnprot) :
                   protEn && (stage_r.code == `FCP_CMD_MASS);

  always_comb begin
    phase_nxt = phase_r;
    stage_nxt = stage_r;
    queue_nxt = queue_r;
    qValid_nxt = qValid_r;
    cbef_nxt = cbef_r;
    div_nxt = div_r;
    divDone_nxt = divDone_r;
    workProt_nxt = workProt_r;
    opt_nxt = opt_r;
    loaded_nxt = 1'b1;
    errSet = stopErr;
    launch = 1'b0;
    pViol_nxt = pViol_r;
    if (!loaded_r) begin
      workProt_nxt = nvProtByte;
      opt_nxt = nvOptByte;
    end
    if (!blocked) begin
      if (arrWr) begin
        if (!divDone_r || !cbef_r || phase_r != fcp_pkg::FCP_PH_IDLE) begin
          errSet = 1'b1;
        end else begin
          stage_nxt.addr = busAddr;
          stage_nxt.data = busWrData;
          phase_nxt = fcp_pkg::FCP_PH_ADDR;
        end
      end
      if (ctlRd && phase_r == fcp_pkg::FCP_PH_CMD) begin
        errSet = 1'b1;
      end
      if (cmdWr) begin
        if (phase_r != fcp_pkg::FCP_PH_ADDR) begin
          errSet = 1'b1;
        end else if (!validCode) begin
          errSet = 1'b1;
        end else if (secured && busBdm && isChange(busWrData)) begin
          errSet = 1'b1;
        end else begin
          stage_nxt.code = busWrData;
          phase_nxt = fcp_pkg::FCP_PH_CMD;
        end
      end else if (ctlWr && phase_r == fcp_pkg::FCP_PH_ADDR) begin
        errSet = 1'b1;
      end else if (ctlWr && phase_r == fcp_pkg::FCP_PH_CMD) begin
        if (statWr && busWrData[`FCP_ST_CBEF]) begin
          launch = 1'b1;
        end else begin
          errSet = 1'b1;
        end
      end else if (ctlWr && sel == 3'd1 && !divDone_r) begin
        div_nxt = busWrData[6:0];
        divDone_nxt = 1'b1;
      end
    end
    if (ctlWr && sel == 3'd2 && busBdm && loaded_r) begin
      workProt_nxt = busWrData;
    end
    if (launch) begin
      phase_nxt = fcp_pkg::FCP_PH_IDLE;
      if (hitProt) begin
        pViol_nxt = 1'b1;
      end else begin
        queue_nxt = stage_r;
        qValid_nxt = 1'b1;
        cbef_nxt = 1'b0;
      end
    end
    if (exTake) begin
      qValid_nxt = 1'b0;
      cbef_nxt = 1'b1;
    end
    if (errSet) begin
      phase_nxt = fcp_pkg::FCP_PH_IDLE;
    end
    if (statWr && busWrData[`FCP_ST_PVIOL] && !launch) begin
      pViol_nxt = 1'b0;
    end
    // set beats clear when both land together
    accErr_nxt = errSet || (accErr_r && !(statWr && busWrData[`FCP_ST_ACCERR]));
    fetch_nxt = busAddr;
    if (vecFetch && redirOn && busAddr >= `FCP_VEC_LO && busAddr <= `FCP_VEC_HI) begin
      fetch_nxt = busAddr - protSize;
    end
    rdData_nxt = 8'h00;
    if (busRd) begin
      unique case (sel)
        3'd1: rdData_nxt = {divDone_r, div_r};
        3'd2: rdData_nxt = workProt_r;
        3'd3: rdData_nxt = {cbef_r, ccf, pViol_r, accErr_r, 4'h0};
        3'd4: rdData_nxt = 8'h00;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      phase_r <= fcp_pkg::FCP_PH_IDLE;
      stage_r <= '0;
      queue_r <= '0;
      qValid_r <= 1'b0;
      cbef_r <= 1'b1;
      accErr_r <= 1'b0;
      pViol_r <= 1'b0;
      div_r <= 7'h00;
      divDone_r <= 1'b0;
      workProt_r <= `FCP_RST_BYTE;
      opt_r <= `FCP_RST_BYTE;
      loaded_r <= 1'b0;
      rdData_r <= 8'h00;
      fetch_r <= 16'h0000;
    end else begin
      phase_r <= phase_nxt;
      stage_r <= stage_nxt;
      queue_r <= queue_nxt;
      qValid_r <= qValid_nxt;
      cbef_r <= cbef_nxt;
      accErr_r <= accErr_nxt;
      pViol_r <= pViol_nxt;
      div_r <= div_nxt;
      divDone_r <= divDone_nxt;
      workProt_r <= workProt_nxt;
      opt_r <= opt_nxt;
      loaded_r <= loaded_nxt;
      rdData_r <= rdData_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // executor and pump
  // ----------------------------------------------------------------
  fcp_pkg::fcp_exst_t ex_r, ex_nxt;
  fcp_pkg::fcp_cmd_t cur_r, cur_nxt;
  logic pump_r, pump_nxt, tmrStart, tmrDone, chain;
  logic [14:0] tmrCount;

  function automatic logic [14:0] cycFor(input logic [7:0] c, input logic fast);
    unique case (c)
      `FCP_CMD_BURST: cycFor = fast ? 15'(CYC_BURST) : 15'(CYC_BYTE);
      `FCP_CMD_BYTE: cycFor = 15'(CYC_BYTE);
      `FCP_CMD_PAGE: cycFor = 15'(CYC_PAGE);
      `FCP_CMD_MASS: cycFor = 15'(CYC_MASS);
      default: cycFor = 15'(CYC_BLANK);
    endcase
  endfunction : cycFor

  // chained only when queued before completion and next byte stays in the row
  assign chain = qValid_r && cur_r.code == `FCP_CMD_BURST && queue_r.code == `FCP_CMD_BURST &&
                 queue_r.addr == cur_r.addr + 16'h0001 &&
                 queue_r.addr[`FCP_ROW_MSB:0] != 6'h00;

  always_comb begin
    ex_nxt = ex_r;
    cur_nxt = cur_r;
    pump_nxt = pump_r;
    exTake = 1'b0;
    tmrStart = 1'b0;
    tmrCount = cycFor(queue_r.code, 1'b0);
    stopErr = 1'b0;
    unique case (ex_r)
      fcp_pkg::FCP_EX_IDLE: begin
        if (qValid_r && !stopMode) begin
          exTake = 1'b1;
          tmrStart = 1'b1;
          cur_nxt = queue_r;
          pump_nxt = queue_r.code != `FCP_CMD_BLANK;
          ex_nxt = fcp_pkg::FCP_EX_RUN;
        end
      end
      fcp_pkg::FCP_EX_RUN: begin
        if (stopMode) begin
          stopErr = 1'b1;
          pump_nxt = 1'b0;
          ex_nxt = fcp_pkg::FCP_EX_IDLE;
        end else if (tmrDone && chain) begin
          exTake = 1'b1;
          tmrStart = 1'b1;
          tmrCount = cycFor(queue_r.code, 1'b1);
          cur_nxt = queue_r;
        end else if (tmrDone) begin
          pump_nxt = 1'b0;
          ex_nxt = fcp_pkg::FCP_EX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ex_r <= fcp_pkg::FCP_EX_IDLE;
      cur_r <= '0;
      pump_r <= 1'b0;
    end else begin
      ex_r <= ex_nxt;
      cur_r <= cur_nxt;
      pump_r <= pump_nxt;
    end
  end

  fcp_timer #(.CW(15)) uTimer (
    .clk(clk),
    .rstN(rstSyncN),
    .div(div_r),
    .start(tmrStart),
    .count(tmrCount),
    .abort(stopErr),
    .busy(),
    .done(tmrDone)
  );

  assign ccf = !qValid_r && ex_r == fcp_pkg::FCP_EX_IDLE;
  assign rdData = rdData_r;
  assign fetchAddr = fetch_r;
  assign pumpOn = pump_r;
  assign arrBusy = ex_r == fcp_pkg::FCP_EX_RUN;
  assign arrCmd = cur_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  AST_NO_LAUNCH_ERR: assert property (accErr_r |-> !launch)
    else $error("command launched while access error set");
  AST_DIV_FIRST: assert property (arrWr && !divDone_r && !blocked |=> accErr_r)
    else $error("array write before divider not flagged");
  AST_ARR_BUSY: assert property (arrWr && !cbef_r && !blocked |=> accErr_r)
    else $error("array write with full buffer not flagged");
  AST_BAD_CODE: assert property (cmdWr && !validCode && !blocked |=> accErr_r)
    else $error("illegal command code not flagged");
  AST_STOP_ABORT: assert property (stopMode && arrBusy |=> accErr_r && !pumpOn && !arrBusy)
    else $error("stop did not abort command");
  AST_CANCEL: assert property (statWr && !busWrData[`FCP_ST_CBEF] &&
      phase_r == fcp_pkg::FCP_PH_CMD && !blocked |=> accErr_r && phase_r == fcp_pkg::FCP_PH_IDLE)
    else $error("cancel did not flag error");
  AST_PROT_APP: assert property (ctlWr && sel == 3'd2 && !busBdm && loaded_r |=> $stable(workProt_r))
    else $error("application changed protection");
  AST_RESET_VEC: assert property (vecFetch && busAddr >= 16'hFFFE |=> fetchAddr == $past(busAddr))
    else $error("reset vector redirected");
  AST_PUMP_OFF: assert property (arrBusy && tmrDone && !chain && !stopMode |=> !pumpOn ##1 1)
    else $error("pump left on without queued burst");
  AST_ERR_DISCARD: assert property (errSet |=> phase_r == fcp_pkg::FCP_PH_IDLE)
    else $error("staged command kept after error");
  AST_CHAIN_PUMP: assert property (arrBusy && tmrDone && chain && !stopMode |=> pumpOn && arrBusy)
    else $error("pump dropped inside burst row");

  COV_LAUNCH: cover property (launch ##[1:40] arrBusy);
  COV_CHAIN: cover property (arrBusy && tmrDone && chain);
  COV_REDIRECT: cover property (vecFetch && redirOn && busAddr == `FCP_VEC_LO);
  COV_STOP: cover property (stopMode && arrBusy);

endmodule : fcp_ctrl

//--- dv/fcp_cpu_model.sv
// cpu / background debug master model for the sequencer's register bus
// assumes one-cycle strobes, launched just after a rising edge
`include "fcp_regs.svh"
module fcp_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdData,
  input wire logic [15:0] fetchAddr,
  output logic [15:0] busAddr,
  output logic [7:0] busWrData,
  output logic busWr,
  output logic busRd,
  output logic busBdm,
  output logic vecFetch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bdm;
  logic vec;

  initial begin
    bdm = 1'b0;
    vec = 1'b0;
    busAddr = 16'h0000;
    busWrData = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    busBdm = 1'b0;
    vecFetch = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic [15:0] f);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWr <= w;
    busRd <= !w;
    busBdm <= bdm;
    vecFetch <= vec && !w;
    @(posedge clk);
    busWr <= 1'b0;
    busRd <= 1'b0;
    busBdm <= 1'b0;
    vecFetch <= 1'b0;
    // idle lines flip so a stale value never looks valid
    busAddr <= ~a;
    busWrData <= ~d;
    #1;
    q = rdData;
    f = fetchAddr;
  endtask : xfer

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [15:0] f;
    xfer(1'b1, a, d, q, f);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] q, output logic [15:0] f);
    xfer(1'b0, a, 8'h00, q, f);
  endtask : rd

  task automatic launch;
    wr(`FCP_ADDR_STATUS, 8'h80);
  endtask : launch

  task automatic clearErr;
    wr(`FCP_ADDR_STATUS, 8'h30);
  endtask : clearErr
endmodule : fcp_cpu_model

//--- dv/flash_command_protect_ctrl_tb.sv
// self-checking bench for the flash command sequencer
// assumes fcp_cpu_model as bus master; long counts shortened by parameters
`include "fcp_regs.svh"
module flash_command_protect_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DIV = 8'h07;
  localparam int TICK = 8;
  localparam int CBU = 2;
  localparam int CBY = 3;
  localparam logic [7:0] NVP = 8'hDE;
  localparam logic [15:0] LU = {NVP[7:1], `FCP_LOW_FILL};
  localparam logic [7:0] CODES [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  localparam logic [7:0] BAD [3] = '{8'h20, 8'h25, 8'h40};
  localparam logic [15:0] VECS [4] = '{16'hFFBF, 16'hFFC0, 16'hFFFD, 16'hFFFE};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic secured = 1'b0;
  logic stopMode = 1'b0;
  logic [7:0] nvProtByte = 8'hFF;
  logic [7:0] nvOptByte = 8'h00;
  logic [15:0] busAddr;
  logic [7:0] busWrData;
  logic busWr;
  logic busRd;
  logic busBdm;
  logic vecFetch;
  logic [7:0] rdData;
  logic [15:0] fetchAddr;
  logic pumpOn;
  logic arrBusy;
  fcp_pkg::fcp_cmd_t arrCmd;
  fcp_pkg::fcp_cmd_t lastCmd;
  logic pumpPrev = 1'b0;
  logic busyPrev = 1'b0;
  logic [7:0] q;
  logic [15:0] f;
  int mismatches = 0;
  int comparisons = 0;
  int pumpFalls = 0;
  int busyCyc = 0;
  int busyRises = 0;
  int n;
  int m;
  int base;

  always #10 clk = ~clk;

  fcp_ctrl #(.CYC_BYTE(CBY), .CYC_BURST(CBU), .CYC_PAGE(10), .CYC_MASS(20), .CYC_BLANK(3)) uut (
    .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
    .busRd(busRd), .busBdm(busBdm), .secured(secured), .stopMode(stopMode),
    .nvProtByte(nvProtByte), .nvOptByte(nvOptByte), .vecFetch(vecFetch), .rdData(rdData),
    .fetchAddr(fetchAddr), .pumpOn(pumpOn), .arrBusy(arrBusy), .arrCmd(arrCmd));

  fcp_cpu_model cpu (
    .clk(clk), .rdData(rdData), .fetchAddr(fetchAddr), .busAddr(busAddr),
    .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busBdm(busBdm),
    .vecFetch(vecFetch));

  // ----------------------------------------------------------------
  // monitor: pump drops, busy cycles, command taken at start
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    pumpPrev <= pumpOn;
    busyPrev <= arrBusy;
    if (pumpPrev === 1'b1 && pumpOn === 1'b0) pumpFalls++;
    if (arrBusy === 1'b1) busyCyc++;
    if (arrBusy === 1'b1 && busyPrev !== 1'b1) begin
      busyRises++;
      lastCmd <= arrCmd;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : report

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    report(got === exp, {24'h0, got}, {24'h0, exp});
  endtask : cmp8

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    report(got === exp, {16'h0, got}, {16'h0, exp});
  endtask : cmp16

  task automatic cmpCmd(input logic [31:0] got, input logic [31:0] exp);
    report(got === exp, got, exp);
  endtask : cmpCmd

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic doReset(input logic [7:0] prot);
    @(posedge clk);
    rst_n <= 1'b0;
    nvProtByte <= prot;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : doReset

  task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    cpu.wr(a, d);
    cpu.wr(`FCP_ADDR_CMD, c);
    cpu.launch();
  endtask : cmd

  task automatic waitIdle;
    int idle;
    idle = 0;
    for (int i = 0; i < 2000 && idle < 3; i++) begin
      @(posedge clk);
      idle = (arrBusy === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 3) mismatches++;
  endtask : waitIdle

  task automatic chkSt(input logic [7:0] exp);
    cpu.rd(`FCP_ADDR_STATUS, q, f);
    cmp8(q, exp);
  endtask : chkSt

  task automatic chkErr;
    waitIdle();
    chkSt(8'hD0);
    cpu.clearErr();
    chkSt(8'hC0);
  endtask : chkErr

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    doReset(8'hFF);
    chkSt(8'hC0);
    n = busyRises;
    cmd(16'h1000, 8'hA5, `FCP_CMD_BYTE);
    chkErr();
    cmp16(16'(busyRises - n), 16'h0000);
    cpu.wr(`FCP_ADDR_CLKDIV, DIV);
    n = busyCyc;
    cmd(16'h1000, 8'hA5, `FCP_CMD_BYTE);
    waitIdle();
    base = busyCyc - n;
    cmp16(16'(base), 16'(CBY * TICK));
    cmpCmd(lastCmd, {16'h1000, 8'hA5, `FCP_CMD_BYTE});
    chkSt(8'hC0);
    foreach (CODES[i]) begin
      cmd(16'h1100 + 16'(i) * 16'h0200, 8'h00, CODES[i]);
      waitIdle();
      cmp8(lastCmd.code, CODES[i]);
      chkSt(8'hC0);
    end
    n = busyCyc;
    m = pumpFalls;
    cmd(16'h2000, 8'h11, `FCP_CMD_BURST);
    repeat (2) @(posedge clk);
    cmd(16'h2001, 8'h22, `FCP_CMD_BURST);
    waitIdle();
    cmp16(16'(busyCyc - n), 16'(base + CBU * TICK));
    cmp16(16'(pumpFalls - m), 16'h0001);
    n = pumpFalls;
    cmd(16'h203E, 8'h33, `FCP_CMD_BURST);
    repeat (2) @(posedge clk);
    cmd(16'h203F, 8'h44, `FCP_CMD_BURST);
    for (int i = 0; i < 60; i++) begin
      cpu.rd(`FCP_ADDR_STATUS, q, f);
      if (q[`FCP_ST_CBEF] === 1'b1) break;
    end
    cmd(16'h2040, 8'h55, `FCP_CMD_BURST);
    waitIdle();
    cmp16(16'(pumpFalls - n), 16'h0002);
    // protocol faults, each followed by clear
    cmd(16'h3000, 8'h01, `FCP_CMD_BYTE);
    repeat (2) @(posedge clk);
    cmd(16'h3001, 8'h01, `FCP_CMD_BYTE);
    cpu.wr(16'h3002, 8'h01);
    chkErr();
    cpu.wr(16'h3010, 8'h01);
    cpu.wr(16'h3011, 8'h01);
    chkErr();
    cpu.wr(16'h3020, 8'h01);
    cpu.wr(`FCP_ADDR_CMD, `FCP_CMD_BYTE);
    cpu.wr(`FCP_ADDR_CMD, `FCP_CMD_BYTE);
    chkErr();
    cpu.wr(16'h3030, 8'h01);
    cpu.wr(`FCP_ADDR_CLKDIV, DIV);
    chkErr();
    cpu.wr(16'h3040, 8'h01);
    cpu.wr(`FCP_ADDR_CMD, 8'h21);
    chkErr();
    cpu.wr(16'h3050, 8'h01);
    cpu.wr(`FCP_ADDR_CMD, `FCP_CMD_BYTE);
    cpu.rd(`FCP_ADDR_PROT, q, f);
    chkErr();
    cpu.wr(16'h3060, 8'h01);
    cpu.wr(`FCP_ADDR_CMD, `FCP_CMD_BYTE);
    cpu.wr(`FCP_ADDR_STATUS, 8'h00);
    chkErr();
    @(posedge clk);
    secured <= 1'b1;
    cpu.bdm = 1'b1;
    foreach (BAD[i]) begin
      cpu.wr(16'h3070, 8'h01);
      cpu.wr(`FCP_ADDR_CMD, BAD[i]);
      chkErr();
    end
    cmd(16'h3080, 8'h00, `FCP_CMD_BLANK);
    waitIdle();
    chkSt(8'hC0);
    cpu.bdm = 1'b0;
    @(posedge clk);
    secured <= 1'b0;
    cmd(16'h3400, 8'h00, `FCP_CMD_PAGE);
    repeat (3) @(posedge clk);
    chkSt(8'h80);
    @(posedge clk);
    stopMode <= 1'b1;
    repeat (2) @(posedge clk);
    stopMode <= 1'b0;
    @(posedge clk);
    cmp8({7'h00, arrBusy}, 8'h00);
    chkErr();
    cpu.vec = 1'b1;
    cpu.rd(16'hFFE0, q, f);
    cmp16(f, 16'hFFE0);
    cpu.vec = 1'b0;
    // second reset: top pages protected, redirect on
    doReset(NVP);
    cpu.wr(`FCP_ADDR_CLKDIV, DIV);
    cpu.vec = 1'b1;
    foreach (VECS[i]) begin
      cpu.rd(VECS[i], q, f);
      cmp16(f, (VECS[i] >= `FCP_VEC_LO && VECS[i] <= `FCP_VEC_HI) ?
                 VECS[i] - (`FCP_TOP_ADDR - LU) : VECS[i]);
    end
    cpu.vec = 1'b0;
    n = busyRises;
    cmd(LU, 8'h66, `FCP_CMD_BYTE);
    waitIdle();
    cmd(LU + 16'h0001, 8'h66, `FCP_CMD_BYTE);
    waitIdle();
    cmp16(16'(busyRises - n), 16'h0001);
    chkSt(8'hE0);
    cpu.clearErr();
    cpu.wr(`FCP_ADDR_PROT, 8'hFF);
    cpu.rd(`FCP_ADDR_PROT, q, f);
    cmp8(q, NVP);
    cpu.bdm = 1'b1;
    cpu.wr(`FCP_ADDR_PROT, 8'hFF);
    cpu.bdm = 1'b0;
    cpu.rd(`FCP_ADDR_PROT, q, f);
    cmp8(q, 8'hFF);
    print_verdict();
  end

  // a run needs well under 20k cycles; stop a hang there
  initial begin
    #400_000;
    mismatches++;
    print_verdict();
  end
endmodule : flash_command_protect_ctrl_tb
